// File: reset_cause_and_watchdog.sv
// Reset cause flags, brown-out decision, bandgap enable and watchdog timer
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "reset_cause_and_watchdog_defines.svh"

module reset_cause_and_watchdog
    import reset_cause_and_watchdog_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        wdt_osc_clk,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  brownout_level_fuses,
    input  wire logic        legacy_compat_fuse,
    input  wire logic        watchdog_always_on_fuse,
    input  wire logic        supply_below_lower,
    input  wire logic        supply_above_upper,
    input  wire logic        pin_reset_active,
    input  wire logic        scan_hold_reset_instruction,
    input  wire logic        watchdog_restart_instruction,
    input  wire logic        comparator_bandgap_select,
    output logic             brownout_detector_enable,
    output logic             bandgap_enable,
    output logic             brownout_reset,
    output logic             watchdog_reset_pulse,
    output logic             core_reset_hold
);

    sys_state_t sq;
    sys_state_t sd;
    wdt_state_t wq;
    wdt_state_t wd;
    wdt_level_t level;
    logic       bod_en;
    logic       reset_src;
    logic       wr_access;
    logic       wde_eff;
    logic       restart_edge;
    logic [21:0] wdt_limit;

    // Fuse decode; reserved codes leave the detector off
    assign bod_en = (brownout_level_fuses != `BOD_CODE_OFF) &&
                    (brownout_level_fuses > `BOD_CODE_RSV_MAX); // [R1]
    assign bandgap_enable = bod_en | comparator_bandgap_select; // [R12]
    assign brownout_detector_enable = bod_en;

    // Fuses are active high here: one means programmed
    always_comb
    begin
        if (watchdog_always_on_fuse)
            level = WDT_LEVEL2; // [R19]
        else if (legacy_compat_fuse)
            level = WDT_LEVEL0; // [R19]
        else
            level = WDT_LEVEL1; // [R19]
    end

    // Level 2 forces the enable whatever the stored bit says
    assign wde_eff   = sq.watchdog_enable_bit | (level == WDT_LEVEL2); // [R20] [R27]
    assign reset_src = scan_hold_reset_instruction | pin_reset_active |
                       sq.bod_active | sq.wdt_pulse;
    assign wr_access = psel & penable & pwrite;

    // Bus answers in the access cycle with no wait state
    assign pready  = 1'b1;
    assign prdata  = {24'h000000, sq.rdata};
    assign pslverr = sq.slverr & psel & penable;

    assign brownout_reset       = sq.bod_active;
    assign watchdog_reset_pulse = sq.wdt_pulse;
    assign core_reset_hold      = sq.hold;

    // System domain next state
    always_comb
    begin
        sd = sq;

        // Brown-out filter and hold
        if (!bod_en)
        begin
            sd.bod_cnt    = 8'h00;
            sd.bod_active = 1'b0;
        end
        else if (sq.bod_active)
        begin
            if (supply_above_upper)
                sd.bod_active = 1'b0; // [R2]
        end
        else if (supply_below_lower)
        begin
            if (sq.bod_cnt == 8'(`BOD_FILTER_CYCLES))
            begin
                sd.bod_active = 1'b1; // [R2] [R3]
                sd.bod_cnt    = 8'h00;
            end
            else
                sd.bod_cnt = sq.bod_cnt + 8'h01; // [R3]
        end
        else
            sd.bod_cnt = 8'h00; // [R3]

        // Release delay reloads while any source is active
        if (reset_src)
            sd.rel_cnt = `RELEASE_DELAY_CYCLES; // [R2] [R5]
        else if (sq.rel_cnt != 16'h0000)
            sd.rel_cnt = sq.rel_cnt - 16'h0001; // [R5]
        sd.hold = reset_src | (sq.rel_cnt != 16'h0000);

        // Change window ages first so a later write can override it
        if (sq.watchdog_change_enable)
        begin
            if (sq.ce_cnt == 3'h0)
                sd.watchdog_change_enable = 1'b0; // [R25]
            else
                sd.ce_cnt = sq.ce_cnt - 3'h1;
        end

        // Flags: software writes zero to clear, sets win
        if (wr_access && paddr == `RCS_OFFSET)
            sd.flags = sq.flags & pwdata[4:0]; // [R11]
        if (scan_hold_reset_instruction)
            sd.flags[`FLAG_SCAN_BIT] = 1'b1; // [R6]
        if (sq.wdt_pulse)
            sd.flags[`FLAG_WDT_BIT] = 1'b1; // [R7]
        if (sq.bod_active)
            sd.flags[`FLAG_BOD_BIT] = 1'b1; // [R8]
        if (pin_reset_active)
            sd.flags[`FLAG_PIN_BIT] = 1'b1; // [R9]

        // Watchdog control writes
        if (wr_access && paddr == `WDC_OFFSET)
        begin
            if (pwdata[`WDC_CE_BIT] && pwdata[`WDC_EN_BIT])
            begin
                sd.watchdog_change_enable   = 1'b1; // [R24]
                sd.ce_cnt = 3'(`WATCHDOG_CHANGE_ENABLE_OPEN_CYCLES - 1); // [R25]
                sd.watchdog_enable_bit    = 1'b1;
                if (level == WDT_LEVEL0)
                    sd.watchdog_prescale_select = pwdata[2:0]; // [R22]
            end
            else if (sq.watchdog_change_enable && !pwdata[`WDC_CE_BIT])
            begin
                sd.watchdog_enable_bit  = pwdata[`WDC_EN_BIT]; // [R24]
                sd.watchdog_prescale_select  = pwdata[2:0]; // [R22] [R24]
                sd.watchdog_change_enable = 1'b0;
            end
            else
            begin
                // Enabling is free, clearing needs the window
                sd.watchdog_enable_bit = sq.watchdog_enable_bit | pwdata[`WDC_EN_BIT]; // [R21]
                if (level == WDT_LEVEL0)
                    sd.watchdog_prescale_select = pwdata[2:0]; // [R22]
            end
        end

        // Chip reset returns control to its initial state
        if (sq.hold)
        begin
            sd.watchdog_change_enable = 1'b0;
            sd.watchdog_enable_bit  = 1'b0; // [R20]
            sd.watchdog_prescale_select  = 3'h0;
        end
        sd.en_tx = (sd.watchdog_enable_bit | (level == WDT_LEVEL2)) & ~sq.hold;

        // Restart instruction crosses as a toggle
        if (watchdog_restart_instruction)
            sd.restart_tgl = ~sq.restart_tgl; // [R15] [R28]

        // Expiry toggle back from the oscillator domain
        sd.exp_sync  = {sq.exp_sync[1:0], wq.exp_tgl}; // [R28]
        sd.wdt_pulse = sq.exp_sync[1] ^ sq.exp_sync[2]; // [R4] [R18]

        // Read data captured in the setup cycle
        if (psel && !penable)
        begin
            sd.slverr = 1'b0;
            if (paddr == `RCS_OFFSET)
                sd.rdata = {3'h0, sq.flags};
            else if (paddr == `WDC_OFFSET)
                sd.rdata = {3'h0, sq.watchdog_change_enable, wde_eff, sq.watchdog_prescale_select}; // [R23] [R27]
            else
            begin
                sd.rdata  = 8'h00;
                sd.slverr = 1'b1;
            end
        end
    end

    // Power-on reset sets only the power-on flag
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sq          <= '0;
            sq.flags    <= `FLAGS_RESET; // [R10]
            sq.rel_cnt  <= `RELEASE_DELAY_CYCLES;
            sq.hold     <= 1'b1;
        end
        else
            sq <= sd;
    end

    // Timeout is base count shifted by the prescale code
    assign wdt_limit    = (`WDT_BASE_CYCLES << wq.wdp_s2) - 22'h000001; // [R17] [R26]
    assign restart_edge = wq.rs_sync[1] ^ wq.rs_sync[2];

    // Watchdog oscillator domain next state
    always_comb
    begin
        wd = wq;
        wd.rs_sync   = {wq.rs_sync[1:0], sq.restart_tgl}; // [R28]
        wd.en_sync   = {wq.en_sync[0], sq.en_tx}; // [R28]
        wd.hold_sync = {wq.hold_sync[0], sq.hold}; // [R28]
        // Prescale is quasi-static; a stray code lasts one tick at most
        wd.wdp_s1    = sq.watchdog_prescale_select; // [R28]
        wd.wdp_s2    = wq.wdp_s1;
        if (wq.hold_sync[1] || !wq.en_sync[1] || restart_edge)
            wd.cnt = 22'h000000; // [R15] [R16]
        else if (wq.cnt >= wdt_limit)
        begin
            wd.cnt     = 22'h000000;
            wd.exp_tgl = ~wq.exp_tgl; // [R18]
        end
        else
            wd.cnt = wq.cnt + 22'h000001; // [R14]
    end

    always_ff @(posedge wdt_osc_clk or negedge resetn)
    begin
        if (!resetn)
            wq <= '0;
        else
            wq <= wd;
    end

    sequence s_ce_open;
        $rose(sq.watchdog_change_enable);
    endsequence

    sequence s_dog_bites;
        sq.wdt_pulse ##1 !sq.wdt_pulse;
    endsequence

    a_wdt_pulse_one: assert property ( // [R4]
        @(posedge clk) disable iff (!resetn)
        $rose(sq.wdt_pulse) |-> s_dog_bites)
        else $error("watchdog pulse not one cycle");

    a_release_after_pulse: assert property ( // [R5]
        @(posedge clk) disable iff (!resetn)
        $fell(sq.wdt_pulse) |-> sq.hold [*2])
        else $error("core not held after watchdog pulse");

    a_watchdog_change_enable_self_clear: assert property ( // [R25]
        @(posedge clk) disable iff (!resetn)
        s_ce_open |-> ##4 !sq.watchdog_change_enable)
        else $error("change enable not cleared after four cycles");

    a_wdt_flag_set: assert property ( // [R7]
        @(posedge clk) disable iff (!resetn)
        sq.wdt_pulse |=> sq.flags[`FLAG_WDT_BIT])
        else $error("watchdog flag not set");

    a_por_flag_keep: assert property ( // [R10]
        @(posedge clk) disable iff (!resetn)
        sq.flags[`FLAG_POR_BIT] && !(wr_access && paddr == `RCS_OFFSET
            && !pwdata[`FLAG_POR_BIT]) |=> sq.flags[`FLAG_POR_BIT])
        else $error("power-on flag lost without software clear");

    a_bod_filter_len: assert property ( // [R3]
        @(posedge clk) disable iff (!resetn)
        $rose(sq.bod_active) |-> $past(sq.bod_cnt) == 8'(`BOD_FILTER_CYCLES))
        else $error("brown-out taken before filter time");

    a_bod_release: assert property ( // [R2]
        @(posedge clk) disable iff (!resetn)
        sq.bod_active && supply_above_upper |=> !sq.bod_active ##1 sq.hold)
        else $error("brown-out release wrong");

    a_wdc_reserved_zero: assert property ( // [R23]
        @(posedge clk) disable iff (!resetn)
        psel && !penable && paddr == `WDC_OFFSET |=> prdata[7:5] == 3'h0)
        else $error("reserved watchdog bits not zero");

    a_level2_enable: assert property ( // [R27]
        @(posedge clk) disable iff (!resetn)
        level == WDT_LEVEL2 && psel && !penable && paddr == `WDC_OFFSET
            |=> prdata[`WDC_EN_BIT])
        else $error("level 2 enable not read as one");

    a_bandgap_follow: assert property ( // [R12]
        @(posedge clk) disable iff (!resetn)
        bandgap_enable == ((brownout_level_fuses inside {3'h3, 3'h4, 3'h5, 3'h6})
            || comparator_bandgap_select))
        else $error("bandgap enable wrong");

    // Decode checked against the list of live codes, not the range compare
    a_bod_code_decode: assert property ( // [R1]
        @(posedge clk) disable iff (!resetn)
        brownout_detector_enable == (brownout_level_fuses inside {3'h3, 3'h4, 3'h5, 3'h6}))
        else $error("brown-out fuse decode wrong");

    a_scan_flag_set: assert property ( // [R6]
        @(posedge clk) disable iff (!resetn)
        scan_hold_reset_instruction |=> sq.flags[`FLAG_SCAN_BIT])
        else $error("scan reset flag not set");

    a_bod_flag_set: assert property ( // [R8]
        @(posedge clk) disable iff (!resetn)
        sq.bod_active |=> sq.flags[`FLAG_BOD_BIT])
        else $error("brown-out flag not set");

    a_pin_flag_set: assert property ( // [R9]
        @(posedge clk) disable iff (!resetn)
        pin_reset_active |=> sq.flags[`FLAG_PIN_BIT])
        else $error("pin reset flag not set");

    // No flag may drop in a cycle without a software write
    a_flags_sticky: assert property ( // [R6] [R7] [R8] [R9] [R10]
        @(posedge clk) disable iff (!resetn)
        !(wr_access && paddr == `RCS_OFFSET)
            |=> (sq.flags & $past(sq.flags)) == $past(sq.flags))
        else $error("reset cause flag dropped without write");

    a_hold_ctrl_clear: assert property ( // [R16] [R20]
        @(posedge clk) disable iff (!resetn)
        sq.hold |=> !sq.watchdog_enable_bit && !sq.watchdog_change_enable && sq.watchdog_prescale_select == 3'h0)
        else $error("watchdog control survived chip reset");

    a_wde_held: assert property ( // [R20] [R24]
        @(posedge clk) disable iff (!resetn)
        sq.watchdog_enable_bit && !sq.watchdog_change_enable && !sq.hold |=> sq.watchdog_enable_bit)
        else $error("watchdog disabled outside the change window");

    a_enable_free: assert property ( // [R21]
        @(posedge clk) disable iff (!resetn)
        wr_access && paddr == `WDC_OFFSET && pwdata[`WDC_EN_BIT] && !sq.hold
            |=> sq.watchdog_enable_bit)
        else $error("enable write refused");

    a_wdp_locked: assert property ( // [R22]
        @(posedge clk) disable iff (!resetn)
        level != WDT_LEVEL0 && !sq.watchdog_change_enable && !sq.hold |=> $stable(sq.watchdog_prescale_select))
        else $error("prescale changed outside the change window");

    a_window_open: assert property ( // [R24]
        @(posedge clk) disable iff (!resetn)
        wr_access && paddr == `WDC_OFFSET && pwdata[`WDC_CE_BIT] && pwdata[`WDC_EN_BIT]
            && !sq.hold |=> sq.watchdog_change_enable && sq.watchdog_enable_bit)
        else $error("change window not opened");

    a_window_apply: assert property ( // [R24]
        @(posedge clk) disable iff (!resetn)
        wr_access && paddr == `WDC_OFFSET && sq.watchdog_change_enable && !pwdata[`WDC_CE_BIT] && !sq.hold
            |=> !sq.watchdog_change_enable && sq.watchdog_prescale_select == $past(pwdata[2:0]))
        else $error("write inside change window not applied");

    a_bod_holds_core: assert property ( // [R2]
        @(posedge clk) disable iff (!resetn)
        brownout_reset |=> core_reset_hold)
        else $error("core not held during brown-out");

    a_wdt_restart_clear: assert property ( // [R15]
        @(posedge wdt_osc_clk) disable iff (!resetn)
        restart_edge |=> wq.cnt == 22'h000000)
        else $error("watchdog counter not cleared on restart");

    // Period derived as a power of two, independent of the base-count shift
    a_wdt_period_sel: assert property ( // [R17] [R26]
        @(posedge wdt_osc_clk) disable iff (!resetn)
        wdt_limit == ((22'h000001 << (5'h0E + 5'(wq.wdp_s2))) - 22'h000001))
        else $error("watchdog period does not match prescale code");

    a_wdt_disable_clear: assert property ( // [R16]
        @(posedge wdt_osc_clk) disable iff (!resetn)
        !wq.en_sync[1] || wq.hold_sync[1] |=> wq.cnt == 22'h000000)
        else $error("watchdog counter not cleared while disabled");

endmodule : reset_cause_and_watchdog

// File: reset_cause_and_watchdog_defines.svh
// Offsets, field positions, reset values and timing counts for reset supervision
// Notes on behaviour
// [R1] Brown-out fuse code: 111 off, 000-010 reserved
// [R2] Brown-out reset immediate; released above upper trigger
// [R3] Ignore supply dips shorter than 2 us
// [R4] Watchdog expiry gives one-cycle reset pulse
// [R5] Release delay starts when watchdog pulse falls
// [R6] Scan reset flag bit 4, sticky
// [R7] Watchdog reset flag bit 3, sticky
// [R8] Brown-out reset flag bit 2, sticky
// [R9] Pin reset flag bit 1, sticky
// [R10] Power-on flag bit 0, only software clears
// [R11] Software reads then clears cause flags early
// [R12] Bandgap on if brown-out or comparator needs
// [R13] Software waits 70 us for bandgap start
// [R14] Watchdog counts on its own 1 MHz oscillator
// [R15] Restart instruction clears watchdog counter
// [R16] Disable or chip reset clears watchdog counter
// [R17] Eight selectable watchdog timeout periods
// [R18] Timeout without restart resets the chip
// [R19] Safety level derived from two fuses
// [R20] Levels 0,1 start off; level 2 always on
// [R21] Setting enable bit always works
// [R22] Timeout change needs timed sequence above level 0
// [R23] Watchdog control bits 7..5 read zero
// [R24] Timed sequence: open, then write within four cycles
// [R25] Change-enable self-clears after four cycles
// [R26] Timeout 16384 cycles doubling to 2097152
// [R27] Level 2 reads enable bit as one
// [R28] Control and expiry cross clock domains safely
`ifndef RESET_CAUSE_AND_WATCHDOG_DEFINES_SVH
`define RESET_CAUSE_AND_WATCHDOG_DEFINES_SVH

`define RCS_OFFSET          12'h000
`define WDC_OFFSET          12'h004

`define FLAG_SCAN_BIT       4
`define FLAG_WDT_BIT        3
`define FLAG_BOD_BIT        2
`define FLAG_PIN_BIT        1
`define FLAG_POR_BIT        0
`define FLAGS_RESET         5'h01

`define WDC_CE_BIT          4
`define WDC_EN_BIT          3

`define BOD_CODE_OFF        3'h7
`define BOD_CODE_RSV_MAX    3'h2

`define CLK_PERIOD_NS       10
`define BOD_MIN_PULSE_NS    2000
`define BOD_FILTER_CYCLES   ((`BOD_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define WATCHDOG_CHANGE_ENABLE_OPEN_CYCLES    4
`define WDT_BASE_CYCLES     22'h004000
`define RELEASE_DELAY_CYCLES 16'h0040

`endif

// File: reset_cause_and_watchdog_pkg.sv
// Types for reset supervision and watchdog
package reset_cause_and_watchdog_pkg;

    typedef enum logic [1:0] {
        WDT_LEVEL0 = 2'h0,
        WDT_LEVEL1 = 2'h1,
        WDT_LEVEL2 = 2'h3
    } wdt_level_t;

    // System clock domain state
    typedef struct packed {
        logic [7:0]  bod_cnt;
        logic        bod_active;
        logic [15:0] rel_cnt;
        logic        hold;
        logic [4:0]  flags;
        logic        watchdog_change_enable;
        logic [2:0]  ce_cnt;
        logic        watchdog_enable_bit;
        logic [2:0]  watchdog_prescale_select;
        logic        en_tx;
        logic        restart_tgl;
        logic [2:0]  exp_sync;
        logic        wdt_pulse;
        logic [7:0]  rdata;
        logic        slverr;
    } sys_state_t;

    // Watchdog oscillator domain state
    typedef struct packed {
        logic [21:0] cnt;
        logic [2:0]  rs_sync;
        logic [1:0]  en_sync;
        logic [1:0]  hold_sync;
        logic [2:0]  wdp_s1;
        logic [2:0]  wdp_s2;
        logic        exp_tgl;
    } wdt_state_t;

endpackage : reset_cause_and_watchdog_pkg

// File: reset_cause_and_watchdog_tb_top.sv
// Self-checking testbench for reset cause flags, brown-out decision and watchdog
`timescale 1ns/1ps
`include "reset_cause_and_watchdog_defines.svh"

module reset_cause_and_watchdog_tb_top
    import reset_cause_and_watchdog_pkg::*;
;
    logic        clk = 1'b0, wdt_osc_clk = 1'b0, resetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        pready, pslverr, slv, lc_fuse, ao_fuse, below, above, pin_rst, scan_rst;
    logic [2:0]  bod_fuses;
    logic        restart, cmp_bg, bod_en, bg_en, bod_rst, wdt_pulse, hold;
    int          n_fail = 0, checked = 0;

    // Oscillator period picked so one short timeout fits the run
    always #5 clk = ~clk;
    always #7 wdt_osc_clk = ~wdt_osc_clk;

    reset_cause_and_watchdog u_reset_cause_and_watchdog (
        .clk(clk), .resetn(resetn), .wdt_osc_clk(wdt_osc_clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .brownout_level_fuses(bod_fuses), .legacy_compat_fuse(lc_fuse),
        .watchdog_always_on_fuse(ao_fuse), .supply_below_lower(below),
        .supply_above_upper(above), .pin_reset_active(pin_rst),
        .scan_hold_reset_instruction(scan_rst), .watchdog_restart_instruction(restart),
        .comparator_bandgap_select(cmp_bg), .brownout_detector_enable(bod_en),
        .bandgap_enable(bg_en), .brownout_reset(bod_rst),
        .watchdog_reset_pulse(wdt_pulse), .core_reset_hold(hold));

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chkb

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            n_fail++;
            final_report();
        end
        rdv = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask : rd_chk

    // Bounded wait for the core hold to drop
    task automatic wait_release;
        int n;
        n = 0;
        while (hold !== 1'b0 && n < 500)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 500)
        begin
            n_fail++;
            final_report();
        end
    endtask : wait_release

    // Fuses are set under power-on reset here; only s_fuses changes the brown-out code outside reset
    task automatic do_reset(input logic [2:0] f, input logic lc, input logic ao);
        @(posedge clk);
        resetn <= 1'b0;
        bod_fuses <= f;
        lc_fuse <= lc;
        ao_fuse <= ao;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        wait_release();
    endtask : do_reset

    task automatic s_regs;
        rd_chk(`RCS_OFFSET, 32'h01);
        rd_chk(`WDC_OFFSET, 32'h00);
        apb(1'b0, 12'h008, 32'h0);
        chk(rdv, 32'h0);
        chkb(slv, 1'b1);
        apb(1'b1, `RCS_OFFSET, 32'hFF);
        rd_chk(`RCS_OFFSET, 32'h01);
        apb(1'b1, `RCS_OFFSET, 32'h00);
        rd_chk(`RCS_OFFSET, 32'h00);
    endtask : s_regs

    task automatic s_fuses;
        for (int c = 0; c < 8; c++)
        begin
            @(posedge clk);
            bod_fuses <= 3'(c);
            cmp_bg <= 1'b0;
            @(negedge clk);
            chkb(bod_en, c >= 3 && c <= 6);
            chkb(bg_en, c >= 3 && c <= 6);
            @(posedge clk);
            // Comparator output is never used, so no start-up wait is owed
            cmp_bg <= 1'b1;
            @(negedge clk);
            chkb(bg_en, 1'b1);
        end
        @(posedge clk);
        bod_fuses <= 3'h7;
        cmp_bg <= 1'b0;
    endtask : s_fuses

    // Pin then scan reset, each leaving only its own flag
    task automatic s_flags;
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, `RCS_OFFSET, 32'h00);
            pin_rst <= (k == 0);
            scan_rst <= (k == 1);
            repeat (3) @(posedge clk);
            chkb(hold, 1'b1);
            pin_rst <= 1'b0;
            scan_rst <= 1'b0;
            @(posedge clk);
            wait_release();
            rd_chk(`RCS_OFFSET, (k == 0) ? 32'h02 : 32'h10);
        end
    endtask : s_flags

    task automatic s_brownout;
        do_reset(3'h4, 1'b0, 1'b0);
        apb(1'b1, `RCS_OFFSET, 32'h00);
        above <= 1'b0;
        below <= 1'b1;
        repeat (150) @(posedge clk);
        below <= 1'b0;
        @(negedge clk);
        chkb(bod_rst, 1'b0);
        @(posedge clk);
        below <= 1'b1;
        repeat (205) @(posedge clk);
        @(negedge clk);
        chkb(bod_rst, 1'b1);
        @(posedge clk);
        below <= 1'b0;
        above <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chkb(bod_rst, 1'b0);
        wait_release();
        rd_chk(`RCS_OFFSET, 32'h04);
        do_reset(3'h7, 1'b0, 1'b0);
        above <= 1'b0;
        below <= 1'b1;
        repeat (250) @(posedge clk);
        chkb(bod_rst, 1'b0);
        below <= 1'b0;
        above <= 1'b1;
    endtask : s_brownout

    // Level 1 then level 0 then level 2 control writes
    task automatic s_wdt_cfg;
        apb(1'b1, `WDC_OFFSET, 32'h0D);
        rd_chk(`WDC_OFFSET, 32'h08);
        apb(1'b1, `WDC_OFFSET, 32'h00);
        rd_chk(`WDC_OFFSET, 32'h08);
        apb(1'b1, `WDC_OFFSET, 32'h18);
        apb(1'b1, `WDC_OFFSET, 32'h03);
        rd_chk(`WDC_OFFSET, 32'h03);
        apb(1'b1, `WDC_OFFSET, 32'h1B);
        repeat (6) @(posedge clk);
        apb(1'b1, `WDC_OFFSET, 32'h05);
        rd_chk(`WDC_OFFSET, 32'h0B);
        apb(1'b1, `WDC_OFFSET, 32'hEB);
        rd_chk(`WDC_OFFSET, 32'h0B);
        do_reset(3'h7, 1'b1, 1'b0);
        apb(1'b1, `WDC_OFFSET, 32'h0D);
        rd_chk(`WDC_OFFSET, 32'h0D);
        apb(1'b1, `WDC_OFFSET, 32'h00);
        rd_chk(`WDC_OFFSET, 32'h08);
        do_reset(3'h7, 1'b0, 1'b1);
        rd_chk(`WDC_OFFSET, 32'h08);
        apb(1'b1, `WDC_OFFSET, 32'h18);
        apb(1'b1, `WDC_OFFSET, 32'h02);
        rd_chk(`WDC_OFFSET, 32'h0A);
    endtask : s_wdt_cfg

    // Restarts keep it quiet past one period; then it must expire
    task automatic s_wdt_expire;
        int n;
        do_reset(3'h7, 1'b0, 1'b0);
        apb(1'b1, `RCS_OFFSET, 32'h00);
        apb(1'b1, `WDC_OFFSET, 32'h08);
        n = 0;
        repeat (2)
        begin
            repeat (12000)
            begin
                @(posedge clk);
                if (wdt_pulse === 1'b1)
                    n++;
            end
            restart <= 1'b1;
            @(posedge clk);
            restart <= 1'b0;
        end
        chkb(n == 0, 1'b1);
        n = 0;
        while (wdt_pulse !== 1'b1 && n < 30000)
        begin
            @(posedge clk);
            n++;
        end
        chkb(n > 20000 && n < 30000, 1'b1);
        @(posedge clk);
        chkb(wdt_pulse, 1'b0);
        repeat (60) @(posedge clk);
        chkb(hold, 1'b1);
        wait_release();
        rd_chk(`RCS_OFFSET, 32'h08);
        rd_chk(`WDC_OFFSET, 32'h00);
    endtask : s_wdt_expire

    // Main sequence
    initial
    begin
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {lc_fuse, ao_fuse, below, pin_rst, scan_rst, restart, cmp_bg} = '0;
        above = 1'b1;
        bod_fuses = 3'h7;
        do_reset(3'h7, 1'b0, 1'b0);
        s_regs();
        s_fuses();
        s_flags();
        s_brownout();
        s_wdt_cfg();
        s_wdt_expire();
        final_report();
    end
endmodule : reset_cause_and_watchdog_tb_top
